/* File: vfcr_regs.sv */
`timescale 1ns/1ns
module vfcr_regs (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Serial bus pins, open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Video timing pulses
	input wire logic vsync,
	input wire logic hsync,
	// Black-line detector
	input wire logic meas_valid,
	input wire logic [6:0] meas_lower,
	input wire logic [6:0] meas_upper,
	input wire logic meas_black_pic,
	output logic blk_restart,
	// Pin drive
	output logic pad_drive_en,
	output logic pad_drive_weak,
	output logic interlace_pin_oe,
	// Sync generator settings
	output logic [7:0] sync_generator_mode,
	output logic [10:0] line_length,
	output logic [10:0] line_readout_start,
	// Priority bus
	output logic [7:0] priority_bus_config,
	output logic priority_request_source,
	// Test pattern
	output logic test_pattern_enable,
	output logic [7:0] test_luma,
	output logic test_chroma_zero,
	// Status
	output logic host_ready
);
	import vfcr_pkg::*;
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		vfcr_init_t ph; // Init phase
		logic [6:0] cnt; // Reset extension count
		logic ld; // Default table step
		logic rdy; // Bus open
		vfcr_i2c_t is; // Bus slave state
		logic [3:0] bc; // Bit count
		logic [7:0] sh; // Shift register
		logic rw; // Read transfer
		logic ackd; // Ack phase flag
		logic [7:0] sub; // Subaddress
		logic [1:0] idx; // Byte index, saturates at 2
		logic [7:0] hi; // Held high byte
		logic oe; // Pull data line low
		logic [15:0] pin;
		logic [15:0] llen;
		logic [15:0] rdst;
		logic [15:0] tpat;
		logic [7:0] sync;
		logic [7:0] prio;
		logic [15:0] llen_a; // Values in effect
		logic [15:0] rdst_a;
		logic [15:0] tpat_a;
		logic [7:0] sync_a;
		logic [6:0] lo; // Black-line counts
		logic [6:0] up;
		logic pic;
		logic rstb; // Measurement restart pulse
		logic [PA_W-1:0] rptr;
		logic [PA_W-1:0] wptr;
		logic [PD_W-1:0] dbuf; // Prefetched read word
		logic wreq; // Status flags
		logic rreq;
		logic mwr; // Memory strobes
		logic mrd;
		logic [PA_W-1:0] mra;
		logic [PA_W-1:0] mwa;
		logic [PD_W-1:0] mwd;
		logic drv_en;
		logic drv_weak;
		logic intl_oe;
		logic [7:0] ramp;
		logic [7:0] luma;
	} vfcr_state_t;
	vfcr_state_t st;
	vfcr_state_t n;
	logic [1:0] pins_s; // Synchronised clock and data
	logic scl_p; // Previous samples
	logic sda_p;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [7:0] rx; // Completed byte
	logic [7:0] rb; // Byte being loaded for reading
	logic rd_evt; // Last byte of a word loaded
	logic wr_evt; // Last byte of a word received
	logic [15:0] wdat;
	logic mem_busy;
	logic mem_rv;
	logic mem_wd;
	logic [PD_W-1:0] mem_rdat;
	// ------------------------------------------------------------
	// Pin synchroniser and memory
	// ------------------------------------------------------------
	vfcr_sync2 #(.W(2)) u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.d({scl_in, sda_in}),
		.q(pins_s)
	);
	vfcr_proc_mem u_mem (
		.mclk(mclk),
		.nrst(nrst),
		.wr_req(st.mwr),
		.wr_addr(st.mwa),
		.wr_data(st.mwd),
		.wr_done(mem_wd),
		.rd_req(st.mrd),
		.rd_addr(st.mra),
		.rd_data(mem_rdat),
		.rd_valid(mem_rv),
		.busy(mem_busy)
	);
	// Edge and condition detection
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_p <= pins_s[1];
			sda_p <= pins_s[0];
		end
	end
	assign scl_rise = pins_s[1] & ~scl_p;
	assign scl_fall = ~pins_s[1] & scl_p;
	assign start_c = pins_s[1] & scl_p & sda_p & ~pins_s[0];
	assign stop_c = pins_s[1] & scl_p & ~sda_p & pins_s[0];
	assign rx = {st.sh[6:0], pins_s[0]};
	// ------------------------------------------------------------
	// Register read view
	// ------------------------------------------------------------
	function automatic logic is8(input logic [7:0] s);
		return (s == SUB_SYNC) || (s == SUB_PRIO) || (s == SUB_PSTA);
	endfunction
	function automatic logic [15:0] rword(input logic [7:0] s);
		logic [15:0] w;
		w = 16'h0000;
		if (s == SUB_BLK) begin
			w = {st.pic, st.up, 1'b0, st.lo};
		end else if (s == SUB_PIN) begin
			w = st.pin;
		end else if (s == SUB_SYNC) begin
			w = {8'h00, st.sync};
		end else if (s == SUB_LLEN) begin
			w = st.llen;
		end else if (s == SUB_RDST) begin
			w = st.rdst;
		end else if (s == SUB_PRIO) begin
			w = {8'h00, st.prio};
		end else if (s == SUB_TPAT) begin
			w = st.tpat;
		end else if (s == SUB_PSTA) begin
			w = {13'h0000, st.wreq | st.rreq | mem_busy, st.rreq, st.wreq};
		end else if (s == SUB_PDAT) begin
			w = {4'h0, st.dbuf};
		end
		return w;
	endfunction
	// High byte first, extra bytes read zero
	function automatic logic [7:0] rbyte(input logic [7:0] s, input logic [1:0] i);
		logic [15:0] w;
		w = rword(s);
		if (is8(s)) begin
			return (i == 2'h0) ? w[7:0] : 8'h00;
		end
		return (i == 2'h0) ? w[15:8] : ((i == 2'h1) ? w[7:0] : 8'h00);
	endfunction
	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n = st;
		rd_evt = 1'b0;
		wr_evt = 1'b0;
		wdat = 16'h0000;
		rb = 8'h00;
		n.mwr = 1'b0;
		n.mrd = 1'b0;
		n.rstb = 1'b0;
		// Reset extension, then default loading
		case (st.ph)
			INIT_HOLD: begin
				if (st.cnt == RST_EXT_CYC - 7'h1) begin
					n.ph = INIT_LOAD;
				end else begin
					n.cnt = st.cnt + 7'h1;
				end
			end
			INIT_LOAD: begin
				if (!st.ld) begin
					n.llen = DEF_LLEN;
					n.ld = 1'b1;
				end else begin
					n.rdst = DEF_RDST;
					n.ph = INIT_DONE;
					n.rdy = 1'b1;
				end
			end
			default: begin
			end
		endcase
		// Serial bus slave
		if (start_c) begin
			n.is = I_ADDR;
			n.bc = 4'h0;
			n.oe = 1'b0;
			n.ackd = 1'b0;
		end else if (stop_c) begin
			n.is = I_IDLE;
			n.oe = 1'b0;
		end else begin
			case (st.is)
				I_ADDR, I_SUB, I_WDAT: begin
					if (scl_rise) begin
						n.sh = rx;
						n.bc = st.bc + 4'h1;
						if (st.bc == 4'h7) begin
							if (st.is == I_ADDR) begin
								// Own chip address only, and only once open
								if (rx[7:1] == CHIP_ADDR && st.rdy) begin
									n.rw = rx[0];
									n.is = I_ACKA;
								end else begin
									n.is = I_IDLE;
								end
							end else if (st.is == I_SUB) begin
								n.sub = rx;
								n.idx = 2'h0;
								n.is = I_ACKS;
							end else begin
								// Wide words: high byte held, low byte commits
								if (st.idx == 2'h0 && !is8(st.sub)) begin
									n.hi = rx;
								end else if (st.idx == 2'h0 || (st.idx == 2'h1 && !is8(st.sub))) begin
									wr_evt = 1'b1;
									wdat = is8(st.sub) ? {8'h00, rx} : {st.hi, rx};
								end
								n.idx = (st.idx == 2'h2) ? 2'h2 : st.idx + 2'h1;
								n.is = I_ACKW;
							end
						end
					end
				end
				I_ACKA, I_ACKS, I_ACKW: begin
					if (scl_fall) begin
						if (!st.ackd) begin
							n.oe = 1'b1;
							n.ackd = 1'b1;
						end else begin
							n.ackd = 1'b0;
							n.oe = 1'b0;
							n.bc = 4'h0;
							if (st.is == I_ACKA && st.rw) begin
								rb = rbyte(st.sub, 2'h0);
								n.idx = 2'h0;
								n.sh = {rb[6:0], 1'b0};
								n.oe = ~rb[7];
								n.is = I_RDAT;
								rd_evt = is8(st.sub);
							end else if (st.is == I_ACKA) begin
								n.is = I_SUB;
							end else begin
								n.is = I_WDAT;
							end
						end
					end
				end
				I_RDAT: begin
					if (scl_rise) begin
						n.bc = st.bc + 4'h1;
					end else if (scl_fall) begin
						if (st.bc == 4'h8) begin
							n.oe = 1'b0;
							n.is = I_RACK;
						end else begin
							n.oe = ~st.sh[7];
							n.sh = {st.sh[6:0], 1'b0};
						end
					end
				end
				I_RACK: begin
					if (scl_rise) begin
						n.ackd = ~pins_s[0];
					end else if (scl_fall) begin
						if (st.ackd) begin
							n.idx = (st.idx == 2'h2) ? 2'h2 : st.idx + 2'h1;
							rb = rbyte(st.sub, n.idx);
							n.sh = {rb[6:0], 1'b0};
							n.oe = ~rb[7];
							n.bc = 4'h0;
							n.ackd = 1'b0;
							n.is = I_RDAT;
							rd_evt = (st.idx == 2'h0) && !is8(st.sub);
						end else begin
							n.is = I_IDLE;
						end
					end
				end
				default: begin
				end
			endcase
		end
		// Register writes, unused bits dropped
		if (wr_evt) begin
			if (st.sub == SUB_PIN) begin
				n.pin = wdat & MASK_PIN;
			end else if (st.sub == SUB_SYNC) begin
				n.sync = wdat[7:0];
			end else if (st.sub == SUB_LLEN) begin
				n.llen = wdat & MASK_LLEN;
			end else if (st.sub == SUB_RDST) begin
				n.rdst = wdat & MASK_RDST;
			end else if (st.sub == SUB_PRIO) begin
				n.prio = wdat[7:0];
			end else if (st.sub == SUB_TPAT) begin
				n.tpat = wdat & MASK_TPAT;
			end else if (st.sub == SUB_PRD) begin
				n.rptr = wdat[PA_W-1:0];
				n.mra = wdat[PA_W-1:0];
				n.mrd = 1'b1;
				n.rreq = 1'b1;
			end else if (st.sub == SUB_PWR) begin
				n.wptr = wdat[PA_W-1:0];
			end else if (st.sub == SUB_PDAT) begin
				n.mwa = st.wptr;
				n.mwd = wdat[PD_W-1:0];
				n.mwr = 1'b1;
				n.wreq = 1'b1;
				n.wptr = st.wptr + 9'h001;
			end
		end
		// Read side effects
		if (rd_evt && st.sub == SUB_BLK) begin
			n.lo = BLK_RESTART;
			n.up = BLK_RESTART;
			n.rstb = 1'b1;
		end else if (rd_evt && st.sub == SUB_PDAT) begin
			n.rptr = st.rptr + 9'h001;
			n.mra = st.rptr + 9'h001;
			n.mrd = 1'b1;
			n.rreq = 1'b1;
		end
		// Memory answers clear flags unless a new request was raised
		if (mem_rv) begin
			n.dbuf = mem_rdat;
			if (!n.mrd) begin
				n.rreq = 1'b0;
			end
		end
		if (mem_wd && !n.mwr) begin
			n.wreq = 1'b0;
		end
		// A new measurement wins over a restart
		if (meas_valid) begin
			n.lo = meas_lower;
			n.up = meas_upper;
			n.pic = meas_black_pic;
		end
		// Latched settings
		if (vsync) begin
			n.llen_a = st.llen;
			n.sync_a = st.sync;
			n.tpat_a = st.tpat;
		end
		if (hsync) begin
			n.rdst_a = st.rdst;
		end
		// Pin drive decode
		n.drv_en = st.pin[2:0] != STR_TRISTATE;
		n.drv_weak = st.pin[2:0] == STR_WEAK;
		n.intl_oe = (st.pin[2:0] != STR_TRISTATE) && !st.pin[PIN_TRI_BIT];
		// Test pattern luma
		n.ramp = (hsync || st.ramp >= LUMA_240) ? RAMP_LOW : st.ramp + 8'h01;
		if (!st.tpat_a[TP_EN_BIT]) begin
			n.luma = 8'h00;
		end else begin
			case (st.tpat_a[TP_LUMA_LSB +: 2])
				2'b00: n.luma = st.ramp;
				2'b01: n.luma = LUMA_16;
				2'b10: n.luma = LUMA_90;
				default: n.luma = LUMA_240;
			endcase
		end
	end
	// ------------------------------------------------------------
	// State register, all zero at reset
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= n;
		end
	end
	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign sda_out = 1'b0 & st.oe;
	assign sda_oe = st.oe;
	assign blk_restart = st.rstb;
	assign pad_drive_en = st.drv_en;
	assign pad_drive_weak = st.drv_weak;
	assign interlace_pin_oe = st.intl_oe;
	assign sync_generator_mode = st.sync_a;
	assign line_length = st.llen_a[10:0];
	assign line_readout_start = st.rdst_a[10:0];
	assign priority_bus_config = st.prio;
	assign priority_request_source = st.prio[PRIO_SRC_BIT];
	assign test_pattern_enable = st.tpat_a[TP_EN_BIT];
	assign test_luma = st.luma;
	assign test_chroma_zero = st.tpat_a[TP_CHROMA_BIT];
	assign host_ready = st.rdy;
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_init_silent: assert property (@(posedge mclk) disable iff (!nrst)
		!st.rdy |-> !st.oe) else $error("bus answered during init");
	a_hold_zero: assert property (@(posedge mclk) disable iff (!nrst)
		st.ph == INIT_HOLD |-> st.llen == RST_ZERO && st.tpat == RST_ZERO)
		else $error("register not cleared by reset");
	a_init_defaults: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(st.rdy) |-> st.llen == DEF_LLEN && st.rdst == DEF_RDST)
		else $error("defaults missing at init end");
	a_vsync_latch: assert property (@(posedge mclk) disable iff (!nrst)
		!vsync |=> $stable(st.llen_a) && $stable(st.tpat_a))
		else $error("vertical setting changed off sync");
	a_hsync_latch: assert property (@(posedge mclk) disable iff (!nrst)
		!hsync |=> $stable(st.rdst_a)) else $error("readout start changed off sync");
	a_blk_restart: assert property (@(posedge mclk) disable iff (!nrst)
		rd_evt && st.sub == SUB_BLK && !meas_valid |=> st.lo == BLK_RESTART
		&& st.up == BLK_RESTART && blk_restart) else $error("black counts not restarted");
	a_rptr_step: assert property (@(posedge mclk) disable iff (!nrst)
		rd_evt && st.sub == SUB_PDAT |=> st.rptr == $past(st.rptr) + 9'h001 && st.rreq)
		else $error("read pointer did not advance");
	a_wptr_step: assert property (@(posedge mclk) disable iff (!nrst)
		wr_evt && st.sub == SUB_PDAT |=> st.wptr == $past(st.wptr) + 9'h001
		&& st.mwr ##1 st.wreq) else $error("write pointer did not advance");
	a_wo_zero: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(st.is == I_RDAT) && (st.sub == SUB_PRD || st.sub == SUB_PWR) |-> st.oe)
		else $error("write-only register read nonzero");
	a_tristate_pin: assert property (@(posedge mclk) disable iff (!nrst)
		st.pin[2:0] == STR_TRISTATE |=> !pad_drive_en && !interlace_pin_oe)
		else $error("pins driven in tristate");
endmodule // vfcr_regs

/* File: vfcr_pkg.sv */
// How it works
// - Nine-bit registers use two bytes, high bits zero
// - Hardware reset clears every control register
// - Post-reset init loads listed default values
// - Vertical/horizontal latched registers update on sync
// - Write-only unreadable, read-write echoes, status reads
// - Status: write pending, read pending, busy
// - Read pointer takes nine address bits
// - Write pointer takes nine address bits
// - Data port access advances its pointer
// - One sixteen-bit word per data telegram
// - Black-line read restarts both counts at 127
// - Black-line word: lower, zero, upper, flag
// - Drive strength code: 7 tristate, 6 weak
// - Bit four tristates the interlace pin
// - Line length eleven bits, default 1295
// - Bit eleven enables the test pattern
// - Luma select: ramp, 16, 90, 240
// - Bit fifteen zeroes the pattern chroma
// - Readout start default 50, above 31; writes of any 11-bit value are accepted
// - Priority request source: video or one
// - Wide registers move as two bytes
// - Chip address then one subaddress byte
// - No bus answer while initializing
package vfcr_pkg;
	// ------------------------------------------------------------
	// Bus address and register offsets
	// ------------------------------------------------------------
	localparam logic [6:0] CHIP_ADDR = 7'h47;
	localparam logic [7:0] SUB_BLK = 8'h12;
	localparam logic [7:0] SUB_PIN = 8'h1f;
	localparam logic [7:0] SUB_SYNC = 8'h20;
	localparam logic [7:0] SUB_LLEN = 8'h21;
	localparam logic [7:0] SUB_RDST = 8'h22;
	localparam logic [7:0] SUB_PRIO = 8'h24;
	localparam logic [7:0] SUB_TPAT = 8'h29;
	localparam logic [7:0] SUB_PSTA = 8'h35;
	localparam logic [7:0] SUB_PRD = 8'h36;
	localparam logic [7:0] SUB_PWR = 8'h37;
	localparam logic [7:0] SUB_PDAT = 8'h38;
	// ------------------------------------------------------------
	// Implemented bits, reset and default values
	// ------------------------------------------------------------
	localparam logic [15:0] MASK_PIN = 16'h003f;
	localparam logic [15:0] MASK_LLEN = 16'h07ff;
	localparam logic [15:0] MASK_RDST = 16'h07ff;
	localparam logic [15:0] MASK_TPAT = 16'hb800;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] DEF_LLEN = 16'h050f;
	localparam logic [15:0] DEF_RDST = 16'h0032;
	localparam logic [6:0] BLK_RESTART = 7'h7f;
	// ------------------------------------------------------------
	// Field positions and codes
	// ------------------------------------------------------------
	localparam int PIN_TRI_BIT = 4;
	localparam int PRIO_SRC_BIT = 4;
	localparam int TP_EN_BIT = 11;
	localparam int TP_LUMA_LSB = 12;
	localparam int TP_CHROMA_BIT = 15;
	localparam logic [2:0] STR_TRISTATE = 3'h7;
	localparam logic [2:0] STR_WEAK = 3'h6;
	localparam logic [7:0] LUMA_16 = 8'h10;
	localparam logic [7:0] LUMA_90 = 8'h5a;
	localparam logic [7:0] LUMA_240 = 8'hf0;
	localparam logic [7:0] RAMP_LOW = 8'h11;
	localparam int PA_W = 9;
	localparam int PD_W = 12;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam int CLK_NS = 1000000000 / CLK_HZ;
	localparam int RST_EXT_NS = 4000;
	localparam logic [6:0] RST_EXT_CYC = 7'((RST_EXT_NS + CLK_NS - 1) / CLK_NS);
	localparam int MEM_LAT_CYC = 4;
	// ------------------------------------------------------------
	// State encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		INIT_HOLD = 2'b00,
		INIT_LOAD = 2'b01,
		INIT_DONE = 2'b10
	} vfcr_init_t;
	typedef enum logic [3:0] {
		I_IDLE = 4'b0000,
		I_ADDR = 4'b0001,
		I_ACKA = 4'b0010,
		I_SUB = 4'b0011,
		I_ACKS = 4'b0100,
		I_WDAT = 4'b0101,
		I_ACKW = 4'b0110,
		I_RDAT = 4'b0111,
		I_RACK = 4'b1000
	} vfcr_i2c_t;
endpackage

/* File: vfcr_sync2.sv */
`timescale 1ns/1ns
module vfcr_sync2 #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Asynchronous in, synchronised out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// ------------------------------------------------------------
	// Two flip-flop stages
	// ------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] s1; // First stage, only read by the second
		logic [W-1:0] s2; // Second stage
	} vfcr_sync_t;
	vfcr_sync_t st;
	vfcr_sync_t n;
	// Next stage values
	always_comb begin
		n.s1 = d;
		n.s2 = st.s1;
	end
	// Registers, idle bus level is high
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st <= '1;
		end else begin
			st <= n;
		end
	end
	assign q = st.s2;
endmodule // vfcr_sync2

/* File: vfcr_proc_mem.sv */
`timescale 1ns/1ns
module vfcr_proc_mem #(
	parameter int LAT = vfcr_pkg::MEM_LAT_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Write request
	input wire logic wr_req,
	input wire logic [vfcr_pkg::PA_W-1:0] wr_addr,
	input wire logic [vfcr_pkg::PD_W-1:0] wr_data,
	output logic wr_done,
	// Read request
	input wire logic rd_req,
	input wire logic [vfcr_pkg::PA_W-1:0] rd_addr,
	output logic [vfcr_pkg::PD_W-1:0] rd_data,
	output logic rd_valid,
	// Service state
	output logic busy
);
	import vfcr_pkg::*;
	// ------------------------------------------------------------
	// Processor memory and its access slot
	// ------------------------------------------------------------
	typedef struct packed {
		logic wp; // Write waiting
		logic rp; // Read waiting
		logic [PA_W-1:0] wa;
		logic [PA_W-1:0] ra;
		logic [PD_W-1:0] wd;
		logic [2:0] cnt; // Access slot counter
		logic [PD_W-1:0] rdat;
		logic rv;
		logic wdn;
	} vfcr_mem_t;
	vfcr_mem_t st;
	vfcr_mem_t n;
	logic do_wr; // Store strobe into the array
	logic [PD_W-1:0] mem [0:(1<<PA_W)-1]; // Word store
	// Serve one access per slot, writes before reads
	always_comb begin
		n = st;
		do_wr = 1'b0;
		n.rv = 1'b0;
		n.wdn = 1'b0;
		if (st.wp || st.rp) begin
			if (st.cnt == 3'(LAT - 1)) begin
				n.cnt = 3'h0;
				if (st.wp) begin
					do_wr = 1'b1;
					n.wp = 1'b0;
					n.wdn = 1'b1;
				end else begin
					n.rdat = mem[st.ra];
					n.rp = 1'b0;
					n.rv = 1'b1;
				end
			end else begin
				n.cnt = st.cnt + 3'h1;
			end
		end
		// New requests win over a completion in the same cycle
		if (wr_req) begin
			n.wp = 1'b1;
			n.wa = wr_addr;
			n.wd = wr_data;
		end
		if (rd_req) begin
			n.rp = 1'b1;
			n.ra = rd_addr;
		end
	end
	// State registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= n;
		end
	end
	// Array write port
	always_ff @(posedge mclk) begin
		if (do_wr) begin
			mem[st.wa] <= st.wd;
		end
	end
	assign wr_done = st.wdn;
	assign rd_data = st.rdat;
	assign rd_valid = st.rv;
	assign busy = st.wp | st.rp;
endmodule // vfcr_proc_mem

/* File: vfcr_host.sv */
`timescale 1ns/1ns
// --------
// Serial bus host model
// --------
module vfcr_host (
	// Clock
	input wire logic mclk,
	// Bus lines, open drain
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	import vfcr_pkg::*;
	// Idle bus: both lines released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Quarter of a bit time, 4 cycles
	task automatic qb();
		repeat (4) @(negedge mclk);
	endtask
	// One bit out, line sampled mid-high
	task automatic bt(input logic b, output logic s);
		sda_low = !b;
		qb();
		scl = 1'b1;
		qb();
		s = sda;
		qb();
		scl = 1'b0;
		qb();
	endtask
	// Start or repeated start
	task automatic st();
		sda_low = 1'b0;
		qb();
		scl = 1'b1;
		qb();
		sda_low = 1'b1;
		qb();
		scl = 1'b0;
		qb();
	endtask
	// Byte, most significant bit first, then ninth bit
	task automatic byt(input logic [7:0] d, input logic nine, output logic [7:0] r,
		output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bt(d[i], r[i]);
		end
		bt(nine, a);
		ack = !a;
	endtask
	// One telegram: chip address, subaddress, one word at most
	task automatic xfer(input logic [7:0] sub, input logic rd, input int n,
		input logic [15:0] wd, output logic [15:0] rdv, output logic ok);
		logic [7:0] r;
		logic a;
		rdv = 16'h0000;
		st();
		byt({CHIP_ADDR, 1'b0}, 1'b1, r, ok);
		byt(sub, 1'b1, r, a);
		ok = ok & a;
		if (rd) begin
			st();
			byt({CHIP_ADDR, 1'b1}, 1'b1, r, a);
			for (int i = n - 1; i >= 0; i--) begin
				byt(8'hff, i == 0, r, a);
				rdv[8*i+:8] = r;
			end
		end else begin
			for (int i = n - 1; i >= 0; i--) begin
				byt(wd[8*i+:8], 1'b1, r, a);
				ok = ok & a;
			end
		end
		sda_low = 1'b1;
		qb();
		scl = 1'b1;
		qb();
		sda_low = 1'b0;
		qb();
	endtask
endmodule // vfcr_host

/* File: video_frontend_control_registers_tb.sv */
`timescale 1ns/1ns
module video_frontend_control_registers_tb;
	import vfcr_pkg::*;
	// --------
	// Signals
	// --------
	logic mclk = 1'b0, nrst = 1'b0, scl, sda_low, sda, sda_out, sda_oe;
	logic vsync = 1'b0, hsync = 1'b0, meas_valid = 1'b0, meas_black_pic = 1'b0;
	logic [6:0] meas_lower = 7'h00, meas_upper = 7'h00;
	logic blk_restart, pad_drive_en, pad_drive_weak, interlace_pin_oe, host_ready;
	logic [7:0] sync_generator_mode, priority_bus_config, test_luma;
	logic [10:0] line_length, line_readout_start;
	logic priority_request_source, test_pattern_enable, test_chroma_zero, ok;
	logic [15:0] v;
	int n_mismatch = 0, cmp_count = 0, cyc = 0, n_rst = 0;
	// Data line with pull-up
	assign sda = !(sda_low | sda_oe);
	// 20 MHz clock
	always #25 mclk = !mclk;
	vfcr_regs dut_u (.mclk, .nrst, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .vsync,
		.hsync, .meas_valid, .meas_lower, .meas_upper, .meas_black_pic, .blk_restart,
		.pad_drive_en, .pad_drive_weak, .interlace_pin_oe, .sync_generator_mode,
		.line_length, .line_readout_start, .priority_bus_config, .priority_request_source,
		.test_pattern_enable, .test_luma, .test_chroma_zero, .host_ready);
	vfcr_host host_u (.mclk, .scl, .sda_low, .sda);
	// Cycle limit and restart pulse count
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (blk_restart === 1'b1) n_rst <= n_rst + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			conclude();
		end
	end
	// --------
	// Helpers
	// --------
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic conclude();
		$display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] s, input logic [15:0] d, input int n = 2);
		host_u.xfer(s, 1'b0, n, d, v, ok);
		chk("ack", 16'(ok), 16'h0001);
	endtask
	task automatic rd(input logic [7:0] s, input int n = 2);
		host_u.xfer(s, 1'b1, n, 16'h0000, v, ok);
	endtask
	// Both sync pulses, one cycle each
	task automatic syncs();
		vsync = 1'b1;
		hsync = 1'b1;
		@(negedge mclk);
		vsync = 1'b0;
		hsync = 1'b0;
		repeat (2) @(negedge mclk);
	endtask
	// --------
	// Scenarios
	// --------
	task automatic t_reset();
		repeat (4) @(negedge mclk);
		chk("line_length", 16'(line_length), 16'h0000);
		chk("test_luma", 16'(test_luma), 16'h0000);
		nrst = 1'b1;
		repeat (60) @(negedge mclk);
		chk("host_ready", 16'(host_ready), 16'h0000);
		for (int i = 0; i < 100 && host_ready !== 1'b1; i++) @(negedge mclk);
		syncs();
		chk("line_length", 16'(line_length), 16'd1295);
		chk("readout", 16'(line_readout_start), 16'd50);
		$display("t_reset done");
	endtask
	task automatic t_wide();
		wr(SUB_LLEN, 16'hffff);
		wr(SUB_RDST, 16'h0040);
		chk("line_length", 16'(line_length), 16'd1295);
		chk("readout", 16'(line_readout_start), 16'd50);
		rd(SUB_LLEN);
		chk("rd line_length", v, 16'h07ff);
		chk("sda_out", 16'(sda_out), 16'h0000);
		syncs();
		chk("line_length", 16'(line_length), 16'h07ff);
		chk("readout", 16'(line_readout_start), 16'h0040);
		wr(SUB_SYNC, 16'h00a5, 1);
		rd(SUB_SYNC, 1);
		chk("rd sync mode", v, 16'h00a5);
		chk("sync_mode", 16'(sync_generator_mode), 16'h0000);
		syncs();
		chk("sync_mode", 16'(sync_generator_mode), 16'h00a5);
		$display("t_wide done");
	endtask
	task automatic t_pattern();
		logic [7:0] lum [4] = '{8'h00, 8'h10, 8'h5a, 8'hf0};
		for (int c = 0; c < 4; c++) begin
			wr(SUB_TPAT, {c[0], 1'b0, c[1:0], 1'b1, 11'h000});
			syncs();
			chk("tp_en", 16'(test_pattern_enable), 16'h0001);
			chk("chroma_zero", 16'(test_chroma_zero), 16'(c[0]));
			if (c == 0) chk("ramp", 16'(test_luma >= 8'h11 && test_luma <= 8'hf0), 16'h0001);
			else chk("luma", 16'(test_luma), 16'(lum[c]));
		end
		wr(SUB_TPAT, 16'h0000);
		syncs();
		chk("tp_en", 16'(test_pattern_enable), 16'h0000);
		$display("t_pattern done");
	endtask
	task automatic t_pins();
		logic [2:0] cd [3] = '{3'h7, 3'h6, 3'h0};
		for (int i = 0; i < 3; i++) begin
			wr(SUB_PIN, {11'h000, i[0], 1'b0, cd[i]});
			repeat (2) @(negedge mclk);
			chk("drive_en", 16'(pad_drive_en), 16'(cd[i] != 3'h7));
			chk("weak", 16'(pad_drive_weak), 16'(cd[i] == 3'h6));
			chk("interlace_pin_oe", 16'(interlace_pin_oe), 16'(cd[i] != 3'h7 && !i[0]));
		end
		wr(SUB_PRIO, 16'h0015, 1);
		chk("prio_src", 16'(priority_request_source), 16'h0001);
		chk("prio_cfg", 16'(priority_bus_config), 16'h0015);
		rd(SUB_PRIO, 1);
		chk("rd prio", v, 16'h0015);
		$display("t_pins done");
	endtask
	task automatic t_proc();
		wr(SUB_PWR, 16'h01fe);
		wr(SUB_PDAT, 16'h0abc);
		wr(SUB_PDAT, 16'h0123);
		rd(SUB_PSTA, 1);
		chk("status", v, 16'h0000);
		wr(SUB_PRD, 16'h01fe);
		rd(SUB_PDAT);
		chk("data 0", v, 16'h0abc);
		rd(SUB_PDAT);
		chk("data 1", v, 16'h0123);
		rd(SUB_PRD);
		chk("rd read ptr", v, 16'h0000);
		$display("t_proc done");
	endtask
	task automatic t_black();
		int k;
		meas_lower = 7'h05;
		meas_upper = 7'h09;
		meas_black_pic = 1'b1;
		meas_valid = 1'b1;
		@(negedge mclk);
		meas_valid = 1'b0;
		k = n_rst;
		rd(SUB_BLK);
		chk("blk word", v, 16'h8905);
		repeat (2) @(negedge mclk);
		chk("restart", 16'(n_rst - k), 16'h0001);
		rd(SUB_BLK);
		chk("blk restart", v & 16'h7fff, 16'h7f7f);
		$display("t_black done");
	endtask
	// Main sequence
	initial begin
		t_reset();
		t_wide();
		t_pattern();
		t_pins();
		t_proc();
		t_black();
		conclude();
	end
endmodule // video_frontend_control_registers_tb
